// File: dsh_pkg.sv
// constants shared by the host end and the device end of the hook control port
// Summary of operation
// - first rising edge latches read/write bit
// - next three edges latch register address
// - write: four rising edges shift data in
// - read: four falling edges shift data out
// - two loadable country compliance registers
// - compliance write while off-hook forwards settings
// - going off-hook forwards stored settings
// - line recovery resends stored settings
// - hook follows off-hook bit or pin
// - overvoltage on-hook blocks going off-hook
// - overcurrent off-hook drops hook, then retries
// - fault flag high while overload present
// - four dc modes, each own transmit limit
// - ac termination selectable with any dc
// - on-hook receive gain 0 dB or -6 dB
// - power-down: no off-hook, no monitoring
// - host times all pulse dialing itself
`default_nettype none
package dsh_pkg;
  // frame layout, counted in rising link clock edges
  localparam logic [3:0] FRAME_EDGES = 4'h8;
  localparam logic [3:0] ADDR_EDGES = 4'h4;
  localparam logic [3:0] LAST_EDGE = 4'h7;
  localparam logic [3:0] ADDR_DONE = 4'h3;
  localparam logic CMD_READ = 1'b1;
  // register addresses
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_CTRY_A = 3'h1;
  localparam logic [2:0] ADDR_CTRY_B = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  // control register fields
  localparam int CTRL_OFF_HOOK = 0;
  localparam int CTRL_PWR_DOWN = 1;
  localparam int CTRL_GAIN_LOW = 2;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // country register A fields: dc mode low, ac impedance high
  localparam int CTRY_DC_LO = 0;
  localparam int CTRY_AC_LO = 2;
  localparam logic [3:0] CTRY_A_RST = 4'h0;
  localparam logic [3:0] CTRY_B_RST = 4'h0;
  // status register fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_HOOK = 1;
  localparam int STAT_OVERVOLT = 2;
  localparam int STAT_OVERCUR = 3;
  // transmit limit code per dc mode, one entry each
  localparam logic [7:0] TX_LIMIT_TABLE = 8'hE4;
  // link clock made by the host from CLK
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
endpackage
`default_nettype wire

// File: dsh_if.sv
// serial control link between the host and the device
`default_nettype none
interface dsh_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic off_hook_pin;
  logic sdo_line;
  // released data line is pulled high
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport host (
    output cs_n,
    output sclk,
    output sdi,
    output off_hook_pin,
    input sdo_line
  );
  modport device (
    input cs_n,
    input sclk,
    input sdi,
    input off_hook_pin,
    output sdo,
    output sdo_oe
  );
endinterface
`default_nettype wire

// File: dsh_sync.sv
// two flip-flop synchroniser, one per bit
`default_nettype none
module dsh_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule
`default_nettype wire

// File: dsh_host.sv
// host end: frames reads and writes on the serial control link
`default_nettype none
module dsh_host (
  input wire logic CLK,
  input wire logic RST,
  dsh_if.host LINK,
  input wire logic START,
  input wire logic RW,
  input wire logic [2:0] ADDR,
  input wire logic [3:0] WDATA,
  input wire logic HOOK_PIN,
  output logic BUSY,
  output logic DONE,
  output logic [3:0] RDATA
);
  typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL} dsh_hstate_e;
  dsh_hstate_e state;
  logic [3:0] div;
  logic [3:0] edge_n;
  logic [7:0] sh;
  logic rd;
  logic sdo_s;
  logic half_done;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic pin;

  // read data comes from the other domain
  dsh_sync #(.W(1)) u_sdo (.clk(CLK), .d(LINK.sdo_line), .q(sdo_s));

  assign half_done = (div == dsh_pkg::HALF_LAST);
  assign BUSY = (state != HS_IDLE);
  assign LINK.cs_n = cs_n;
  assign LINK.sclk = sclk;
  assign LINK.sdi = sdi;
  assign LINK.off_hook_pin = pin;

  ////////////////////////////////////////////////////////////////////////
  // hook pin driven straight from the user; dial timing is the user's job
  always_ff @(posedge CLK) begin
    if (RST) pin <= 1'b0;
    else pin <= HOOK_PIN;
  end

  ////////////////////////////////////////////////////////////////////////
  // half period divider, restarts on every phase change
  always_ff @(posedge CLK) begin
    if (RST || state == HS_IDLE || half_done) div <= 4'h0;
    else div <= div + 4'h1;
  end

  // frame sequencer: bit set up while clock low, taken at the rise
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= HS_IDLE;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdi <= 1'b0;
      edge_n <= 4'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      case (state)
        HS_IDLE: begin
          if (START) begin
            cs_n <= 1'b0;
            sh <= {RW, ADDR, WDATA};
            sdi <= RW;
            rd <= (RW == dsh_pkg::CMD_READ);
            edge_n <= 4'h0;
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (half_done) begin
            sclk <= 1'b1;
            state <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (half_done) begin
            sclk <= 1'b0;
            edge_n <= edge_n + 4'h1;
            if (edge_n == dsh_pkg::LAST_EDGE) begin
              state <= HS_TAIL;
            end else begin
              sh <= {sh[6:0], 1'b0};
              sdi <= sh[6];
              state <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          if (half_done) begin
            cs_n <= 1'b1;
            DONE <= 1'b1;
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // read bits are sampled as the clock rises on edges five to eight
  always_ff @(posedge CLK) begin
    if (RST) RDATA <= 4'h0;
    else if (state == HS_LOW && half_done && rd && edge_n >= dsh_pkg::ADDR_EDGES)
      RDATA <= {RDATA[2:0], sdo_s};
  end
endmodule
`default_nettype wire

// File: dsh_device.sv
// device end: serial register port, hook control and line side forwarding
`default_nettype none
module dsh_device (
  input wire logic CLK,
  input wire logic RST,
  dsh_if.device LINK,
  input wire logic OVERVOLT,
  input wire logic OVERCURRENT,
  input wire logic LINE_RESTORED,
  output logic OFF_HOOK,
  output logic LINE_FAULT,
  output logic POWER_DOWN,
  output logic MONITOR_EN,
  output logic RX_GAIN_LOW,
  output logic [1:0] DC_TERM,
  output logic [1:0] AC_TERM,
  output logic [1:0] TX_LIMIT,
  output logic [7:0] LINE_CFG,
  output logic LINE_CFG_LOAD
);
  // link clock domain
  logic [3:0] cnt;
  logic [6:0] sh;
  logic [7:0] frame;
  logic rd_mode;
  logic [3:0] rd_word;
  logic [6:0] wr_hold;
  // start value lets the toggle work without a reset in this domain,
  // since the link clock need not run while RST is high
  logic wr_toggle = 1'b0;
  logic [15:0] mirror_s;
  logic [2:0] rd_addr;
  logic [1:0] bit_idx;
  // system clock domain
  logic [3:0] ctrl;
  logic [3:0] ctry_a;
  logic [3:0] ctry_b;
  logic [3:0] next_ctrl;
  logic [3:0] next_ctry_a;
  logic [3:0] next_ctry_b;
  logic [3:0] status;
  logic wr_sync;
  logic wr_seen;
  logic wr_evt;
  logic [3:0] pins_s;
  logic ov_s;
  logic oc_s;
  logic rest_s;
  logic pin_s;
  logic rest_seen;
  logic hook_cmd;
  logic next_hook;
  logic ctry_wr;
  logic send;

  ////////////////////////////////////////////////////////////////////////
  // serial side, clocked by the link clock

  assign frame = {sh, LINK.sdi};
  assign rd_addr = {sh[1:0], LINK.sdi};
  assign bit_idx = 2'(dsh_pkg::LAST_EDGE - cnt);

  // edge counter; a released select clears it, dropping any partial frame
  always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) cnt <= 4'h0;
    else if (cnt != dsh_pkg::FRAME_EDGES) cnt <= cnt + 4'h1;
  end

  // command, address and write data all enter on rising edges
  always_ff @(posedge LINK.sclk) begin
    if (cnt != dsh_pkg::FRAME_EDGES) sh <= frame[6:0];
  end

  // read word chosen once the third address bit is in
  always_ff @(posedge LINK.sclk) begin
    if (cnt == dsh_pkg::ADDR_DONE) begin
      rd_mode <= (sh[2] == dsh_pkg::CMD_READ);
      case (rd_addr)
        dsh_pkg::ADDR_CTRL: rd_word <= mirror_s[3:0];
        dsh_pkg::ADDR_CTRY_A: rd_word <= mirror_s[7:4];
        dsh_pkg::ADDR_CTRY_B: rd_word <= mirror_s[11:8];
        dsh_pkg::ADDR_STATUS: rd_word <= mirror_s[15:12];
        default: rd_word <= 4'h0;
      endcase
    end
  end

  // a write is committed only on the eighth edge, never earlier
  always_ff @(posedge LINK.sclk) begin
    if (cnt == dsh_pkg::LAST_EDGE && frame[7] != dsh_pkg::CMD_READ) begin
      wr_hold <= frame[6:0];
      wr_toggle <= ~wr_toggle;
    end
  end

  // read data leaves on the four falling edges after the address
  always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      LINK.sdo <= 1'b1;
      LINK.sdo_oe <= 1'b0;
    end else if (rd_mode && cnt >= dsh_pkg::ADDR_EDGES && cnt <= dsh_pkg::LAST_EDGE) begin
      LINK.sdo <= rd_word[bit_idx];
      LINK.sdo_oe <= 1'b1;
    end else begin
      LINK.sdo <= 1'b1;
      LINK.sdo_oe <= 1'b0;
    end
  end

  // control and country registers change only long before a read, so a per-bit sync is enough
  dsh_sync #(.W(16)) u_mirror (
    .clk(LINK.sclk),
    .d({status, ctry_b, ctry_a, ctrl}),
    .q(mirror_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // system side, clocked by CLK

  dsh_sync #(.W(1)) u_wr (.clk(CLK), .d(wr_toggle), .q(wr_sync));
  dsh_sync #(.W(4)) u_pins (
    .clk(CLK),
    .d({LINK.off_hook_pin, LINE_RESTORED, OVERCURRENT, OVERVOLT}),
    .q(pins_s)
  );
  assign ov_s = pins_s[0];
  assign oc_s = pins_s[1];
  assign rest_s = pins_s[2];
  assign pin_s = pins_s[3];

  // write arrival: toggle change, held word already stable
  always_ff @(posedge CLK) begin
    if (RST) wr_seen <= wr_sync;
    else wr_seen <= wr_sync;
  end
  assign wr_evt = wr_sync ^ wr_seen;

  // register update from a committed write
  always_comb begin
    next_ctrl = ctrl;
    next_ctry_a = ctry_a;
    next_ctry_b = ctry_b;
    if (wr_evt) begin
      case (wr_hold[6:4])
        dsh_pkg::ADDR_CTRL: next_ctrl = wr_hold[3:0];
        dsh_pkg::ADDR_CTRY_A: next_ctry_a = wr_hold[3:0];
        dsh_pkg::ADDR_CTRY_B: next_ctry_b = wr_hold[3:0];
        default: next_ctrl = ctrl;
      endcase
    end
  end
  assign ctry_wr = wr_evt &&
    (wr_hold[6:4] == dsh_pkg::ADDR_CTRY_A || wr_hold[6:4] == dsh_pkg::ADDR_CTRY_B);

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= dsh_pkg::CTRL_RST;
      ctry_a <= dsh_pkg::CTRY_A_RST;
      ctry_b <= dsh_pkg::CTRY_B_RST;
    end else begin
      ctrl <= next_ctrl;
      ctry_a <= next_ctry_a;
      ctry_b <= next_ctry_b;
    end
  end

  // hook command from the bit or the pin, never in power-down
  assign hook_cmd = (ctrl[dsh_pkg::CTRL_OFF_HOOK] | pin_s) &
    ~ctrl[dsh_pkg::CTRL_PWR_DOWN];

  // overvoltage blocks the hook, overcurrent drops it; retry is implicit
  // so a standing overcurrent makes the hook oscillate
  always_comb begin
    if (OFF_HOOK) next_hook = hook_cmd & ~oc_s;
    else next_hook = hook_cmd & ~ov_s;
  end

  always_ff @(posedge CLK) begin
    if (RST) OFF_HOOK <= 1'b0;
    else OFF_HOOK <= next_hook;
  end

  // fault flag follows the overload condition
  always_ff @(posedge CLK) begin
    if (RST) LINE_FAULT <= 1'b0;
    else LINE_FAULT <= ov_s | oc_s;
  end

  always_ff @(posedge CLK) begin
    if (RST) rest_seen <= 1'b0;
    else rest_seen <= rest_s;
  end

  // forwarding events to the line side
  assign send = (next_hook & ~OFF_HOOK) |
    (ctry_wr & OFF_HOOK) |
    (rest_s & ~rest_seen);

  always_ff @(posedge CLK) begin
    if (RST) begin
      LINE_CFG <= {dsh_pkg::CTRY_B_RST, dsh_pkg::CTRY_A_RST};
      LINE_CFG_LOAD <= 1'b0;
    end else begin
      LINE_CFG_LOAD <= send;
      if (send) LINE_CFG <= {next_ctry_b, next_ctry_a};
    end
  end

  // option outputs, each from a flip-flop
  always_ff @(posedge CLK) begin
    if (RST) begin
      POWER_DOWN <= 1'b0;
      MONITOR_EN <= 1'b0;
      RX_GAIN_LOW <= 1'b0;
      DC_TERM <= 2'h0;
      AC_TERM <= 2'h0;
      TX_LIMIT <= 2'h0;
    end else begin
      POWER_DOWN <= ctrl[dsh_pkg::CTRL_PWR_DOWN];
      MONITOR_EN <= ~ctrl[dsh_pkg::CTRL_PWR_DOWN];
      RX_GAIN_LOW <= ctrl[dsh_pkg::CTRL_GAIN_LOW];
      DC_TERM <= ctry_a[dsh_pkg::CTRY_DC_LO +: 2];
      AC_TERM <= ctry_a[dsh_pkg::CTRY_AC_LO +: 2];
      TX_LIMIT <= dsh_pkg::TX_LIMIT_TABLE[{ctry_a[dsh_pkg::CTRY_DC_LO +: 2], 1'b0} +: 2];
    end
  end

  // status word seen by reads
  always_comb begin
    status = 4'h0;
    status[dsh_pkg::STAT_FAULT] = LINE_FAULT;
    status[dsh_pkg::STAT_HOOK] = OFF_HOOK;
    status[dsh_pkg::STAT_OVERVOLT] = ov_s;
    status[dsh_pkg::STAT_OVERCUR] = oc_s;
  end
endmodule
`default_nettype wire

// File: dsh_chk.sv
// assertions on the serial control link between the host and the device ends
`default_nettype none
module dsh_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic rw_q;
  logic [3:0] cnt;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  // link clock one sample back; it is a CLK flop, so sampling on CLK sees every edge
  always_ff @(posedge CLK) begin
    sclk_q <= sclk;
  end
  // rising link edges in the current frame, cleared while select is high
  always_ff @(posedge CLK) begin
    if (RST || cs_n) begin
      cnt <= 4'h0;
    end else if (sclk && !sclk_q) begin
      cnt <= cnt + 4'h1;
    end
  end
  // command bit of the frame, taken at its first rising edge
  always_ff @(posedge CLK) begin
    if (sclk && !sclk_q && cnt == 4'h0) begin
      rw_q <= sdi;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock moved outside a frame");
  chk_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase not four cycles");
  chk_cs_setup: assert property ($fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("first link edge not four cycles after select");
  chk_sdi_stable: assert property ($rose(sclk) |-> $stable(sdi) [*4])
    else $error("host data moved while link clock high");
  chk_frame_len: assert property ($rose(cs_n) |-> cnt == dsh_pkg::FRAME_EDGES)
    else $error("frame did not hold eight rising edges");
  chk_oe_start: assert property ($rose(sdo_oe) |-> $fell(sclk)
    && cnt == dsh_pkg::ADDR_EDGES && rw_q == dsh_pkg::CMD_READ)
    else $error("read data driven at the wrong edge");
  chk_oe_write: assert property (!cs_n && cnt != 4'h0
    && rw_q != dsh_pkg::CMD_READ |-> !sdo_oe)
    else $error("device drove data in a write frame");
  chk_oe_drop: assert property ($fell(sclk) && cnt == dsh_pkg::FRAME_EDGES |-> !sdo_oe)
    else $error("device held data line after last edge");
  chk_sdo_stable: assert property (sdo_oe && $past(sdo_oe) && !$fell(sclk)
    |-> $stable(sdo))
    else $error("read data moved off a falling edge");
  ////////////////////////////////////////////////////////////////////////////////
  cov_write: cover property ($rose(cs_n) && rw_q != dsh_pkg::CMD_READ);
  cov_read: cover property ($rose(cs_n) && rw_q == dsh_pkg::CMD_READ);
  cov_drive: cover property ($rose(sdo_oe));
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench: host and device ends joined, plus a bare device driven by the bench
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0, rw = 1'b0, hook_pin = 1'b0, ov = 1'b0, oc = 1'b0, restored = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [3:0] wdata = 4'h0;
  logic busy, done, off_hook, line_fault, power_down, monitor_en, gain_low, load, off_hook_b;
  logic [3:0] rdata;
  logic [1:0] dc_term, ac_term, tx_limit;
  logic [7:0] line_cfg, last_cfg;
  int mismatches = 0, n_compared = 0, n_load = 0, cycles = 0;
  dsh_if link ();
  dsh_if link_b ();
  always #10 clk = ~clk;
  dsh_host i_dsh_host (.CLK(clk), .RST(rst), .LINK(link.host), .START(start), .RW(rw),
    .ADDR(addr), .WDATA(wdata), .HOOK_PIN(hook_pin), .BUSY(busy), .DONE(done), .RDATA(rdata));
  dsh_device i_dsh_device (.CLK(clk), .RST(rst), .LINK(link.device), .OVERVOLT(ov),
    .OVERCURRENT(oc), .LINE_RESTORED(restored), .OFF_HOOK(off_hook), .LINE_FAULT(line_fault),
    .POWER_DOWN(power_down), .MONITOR_EN(monitor_en), .RX_GAIN_LOW(gain_low),
    .DC_TERM(dc_term), .AC_TERM(ac_term), .TX_LIMIT(tx_limit), .LINE_CFG(line_cfg),
    .LINE_CFG_LOAD(load));
  // second device: its link is driven by the bench so frames can be broken
  dsh_device i_dsh_device_b (.CLK(clk), .RST(rst), .LINK(link_b.device), .OVERVOLT(1'b0),
    .OVERCURRENT(1'b0), .LINE_RESTORED(1'b0), .OFF_HOOK(off_hook_b), .LINE_FAULT(),
    .POWER_DOWN(), .MONITOR_EN(), .RX_GAIN_LOW(), .DC_TERM(), .AC_TERM(), .TX_LIMIT(),
    .LINE_CFG(), .LINE_CFG_LOAD());
  dsh_chk i_dsh_chk (.CLK(clk), .RST(rst), .cs_n(link.cs_n), .sclk(link.sclk),
    .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // load pulse lasts one cycle, so count it here rather than poll it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (load === 1'b1) begin
      n_load <= n_load + 1;
      last_cfg <= line_cfg;
    end
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one host frame, then time for the clk side registers to settle
  task automatic xfer(input logic r, input logic [2:0] a, input logic [3:0] d);
    @(negedge clk);
    start = 1'b1;
    rw = r;
    addr = a;
    wdata = d;
    @(negedge clk);
    start = 1'b0;
    check("busy", 8'(busy), 8'h01);
    while (done !== 1'b1) @(negedge clk);
    check("idle", 8'(busy), 8'h00);
    repeat (8) @(negedge clk);
  endtask
  // read twice: the read mirror only moves while the link clock runs
  task automatic rd(input logic [2:0] a);
    xfer(1'b1, a, 4'h0);
    xfer(1'b1, a, 4'h0);
  endtask
  // bench frame on the second link; fewer than eight edges is an abort
  task automatic frame_b(input logic [7:0] bits, input int edges);
    link_b.cs_n = 1'b0;
    for (int i = 0; i < edges; i++) begin
      link_b.sdi = bits[7-i];
      #15 link_b.sclk = 1'b1;
      #15 link_b.sclk = 1'b0;
    end
    #15 link_b.cs_n = 1'b1;
    link_b.sdi = ~link_b.sdi;
    repeat (8) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_hook_bit();
    int n0;
    n0 = n_load;
    xfer(1'b0, dsh_pkg::ADDR_CTRY_B, 4'h5);
    check("load_onhook", 8'(n_load - n0), 8'h00);
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h1);
    check("off_hook", 8'(off_hook), 8'h01);
    check("load_offhook", 8'(n_load - n0), 8'h01);
    check("cfg_offhook", last_cfg, 8'h50);
  endtask
  task automatic t_country();
    int n0;
    for (int m = 0; m < 4; m++) begin
      n0 = n_load;
      xfer(1'b0, dsh_pkg::ADDR_CTRY_A, 4'((3 - m) * 4 + m));
      check("dc_term", 8'(dc_term), 8'(m));
      check("ac_term", 8'(ac_term), 8'(3 - m));
      check("tx_limit", 8'(tx_limit), 8'(dsh_pkg::TX_LIMIT_TABLE[2*m+:2]));
      check("load_ctry", 8'(n_load - n0), 8'h01);
      check("cfg_ctry", last_cfg, 8'(8'h50 + (3 - m) * 4 + m));
    end
  endtask
  task automatic t_read();
    rd(dsh_pkg::ADDR_CTRY_A);
    check("rd_ctry_a", 8'(rdata), 8'h03);
    rd(dsh_pkg::ADDR_CTRY_B);
    check("rd_ctry_b", 8'(rdata), 8'h05);
    // a write to an unmapped address must leave every register alone
    xfer(1'b0, 3'h5, 4'hF);
    rd(3'h5);
    check("rd_unmapped", 8'(rdata), 8'h00);
    rd(dsh_pkg::ADDR_CTRL);
    check("rd_ctrl", 8'(rdata), 8'h01);
  endtask
  task automatic t_restore();
    int n0;
    n0 = n_load;
    restored = 1'b1;
    repeat (8) @(negedge clk);
    restored = 1'b0;
    check("load_restore", 8'(n_load - n0), 8'h01);
  endtask
  task automatic t_overcur();
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    oc = 1'b1;
    repeat (6) @(negedge clk);
    check("fault_oc", 8'(line_fault), 8'h01);
    // hook keeps dropping and retrying while the command stands
    repeat (8) begin
      @(negedge clk);
      if (off_hook === 1'b0) lo++;
      if (off_hook === 1'b1) hi++;
    end
    check("oc_drop", 8'(lo != 0), 8'h01);
    check("oc_retry", 8'(hi != 0), 8'h01);
    rd(dsh_pkg::ADDR_STATUS);
    check("stat_oc", 8'(rdata & 4'h9), 8'h09);
    oc = 1'b0;
    repeat (8) @(negedge clk);
    check("oc_clear", 8'({line_fault, off_hook}), 8'h01);
  endtask
  task automatic t_overvolt();
    int n0;
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h0);
    ov = 1'b1;
    repeat (6) @(negedge clk);
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h1);
    check("ov_block", 8'({line_fault, off_hook}), 8'h02);
    n0 = n_load;
    ov = 1'b0;
    repeat (8) @(negedge clk);
    check("ov_clear", 8'({line_fault, off_hook}), 8'h01);
    check("load_ov", 8'(n_load - n0), 8'h01);
  endtask
  task automatic t_power();
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h7);
    check("pwr_down", 8'({off_hook, power_down, monitor_en}), 8'h02);
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h4);
    check("gain_low", 8'({off_hook, monitor_en, gain_low}), 8'h03);
    xfer(1'b0, dsh_pkg::ADDR_CTRL, 4'h0);
    check("gain_high", 8'(gain_low), 8'h00);
  endtask
  // bench toggles the hook pin as a host dialing pulses would
  task automatic t_pin();
    repeat (2) begin
      hook_pin = 1'b1;
      repeat (8) @(negedge clk);
      check("pin_off", 8'(off_hook), 8'h01);
      hook_pin = 1'b0;
      repeat (8) @(negedge clk);
      check("pin_on", 8'(off_hook), 8'h00);
    end
  endtask
  task automatic t_abort();
    frame_b(8'h01, 7);
    check("abort", 8'(off_hook_b), 8'h00);
    frame_b(8'h01, 8);
    check("full", 8'(off_hook_b), 8'h01);
    frame_b(8'h80, 8);
    check("read_keeps", 8'(off_hook_b), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // select starts low and rises later, so the edge counter surely clears
    link_b.cs_n = 1'b0;
    link_b.sclk = 1'b0;
    link_b.sdi = 1'b0;
    link_b.off_hook_pin = 1'b0;
    repeat (5) @(negedge clk);
    link_b.cs_n = 1'b1;
    rst = 1'b0;
    @(negedge clk);
    check("reset", 8'({off_hook, line_fault, gain_low, monitor_en}), 8'h01);
    check("reset_cfg", line_cfg, 8'h00);
    t_hook_bit();
    t_country();
    t_read();
    t_restore();
    t_overcur();
    t_overvolt();
    t_power();
    t_pin();
    t_abort();
    print_verdict();
  end
endmodule
`default_nettype wire
